// ===== rtl/alu_diag_regs.sv
`timescale 1ns/100ps
`default_nettype none
module alu_diag_regs #(
    parameter int ADC_W = 12
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [9:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // measurement path
    input  wire logic              oversampling,
    input  wire logic              sample_even,
    input  wire logic              conv_second,
    input  wire logic [ADC_W-1:0]  adc_result,
    output logic      [ADC_W-1:0]  alu_input,
    output logic                   alu_injecting,
    // analog test controls
    output logic      [4:0]        test_current_steps,
    output logic                   aux_test_source,
    output logic                   mux_even_out_on,
    output logic                   mux_odd_out_on,
    output logic                   mux_dual_source,
    output logic      [3:0]        diag_source_select_one,
    output logic      [3:0]        diag_source_select_two
);
    logic [11:0] alu_arg_even_first;
    logic [11:0] alu_arg_even_second;
    logic [15:0] diag_config;
    logic [1:0]  alu_selftest_select;
    logic [11:0] next_first;
    logic [11:0] next_second;
    logic [15:0] next_config;
    logic [1:0]  next_select;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic [ADC_W-1:0] next_alu;
    logic        next_inj;
    logic        req;
    logic        wr;
    logic [7:0]  idx;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign idx = wb_adr_i[9:2];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb begin
        next_first  = alu_arg_even_first;
        next_second = alu_arg_even_second;
        next_config = diag_config;
        next_select = alu_selftest_select;
        next_ack    = req;
        next_rdata  = wb_dat_o;
        if (wr) begin
            case (idx)
                alu_diag_pkg::idx_even_first:
                    next_first = 12'(merge16({4'h0, alu_arg_even_first}, wb_dat_i, wb_sel_i));
                alu_diag_pkg::idx_even_second:
                    next_second = 12'(merge16({4'h0, alu_arg_even_second}, wb_dat_i, wb_sel_i));
                alu_diag_pkg::idx_diag_config:
                    next_config = merge16(diag_config, wb_dat_i, wb_sel_i);
                alu_diag_pkg::idx_selftest: begin
                    if (wb_sel_i[0]) begin
                        next_select = wb_dat_i[1:0];
                    end
                end
                default: ;
            endcase
        end
        if (req & ~wb_we_i) begin
            case (idx)
                alu_diag_pkg::idx_even_first:  next_rdata = {20'h00000, alu_arg_even_first};
                alu_diag_pkg::idx_even_second: next_rdata = {20'h00000, alu_arg_even_second};
                alu_diag_pkg::idx_diag_config: next_rdata = {16'h0000, diag_config};
                alu_diag_pkg::idx_selftest:    next_rdata = {30'h0, alu_selftest_select};
                default:                       next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alu_arg_even_first  <= alu_diag_pkg::arg_reset;
            alu_arg_even_second <= alu_diag_pkg::arg_reset;
            diag_config         <= alu_diag_pkg::diag_reset;
            alu_selftest_select <= alu_diag_pkg::selftest_reset;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h00000000;
        end else if (ce) begin
            alu_arg_even_first  <= next_first;
            alu_arg_even_second <= next_second;
            diag_config         <= next_config;
            alu_selftest_select <= next_select;
            wb_ack_o            <= next_ack;
            wb_dat_o            <= next_rdata;
        end
    end

    // measurement path substitution
    always_comb begin
        next_inj = 1'b0;
        // only select one arms the arguments
        if (alu_selftest_select == alu_diag_pkg::selftest_alu && oversampling && sample_even) begin
            next_inj = 1'b1;
        end
        next_alu = adc_result;
        if (next_inj) begin
            next_alu = conv_second ? ADC_W'(alu_arg_even_second) : ADC_W'(alu_arg_even_first);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alu_input     <= '0;
            alu_injecting <= 1'b0;
        end else if (ce) begin
            alu_input     <= next_alu;
            alu_injecting <= next_inj;
        end
    end

    assign test_current_steps = {1'b0, diag_config[alu_diag_pkg::level_lsb +: 4]} + 5'h01;
    assign aux_test_source = diag_config[alu_diag_pkg::polarity_bit];
    assign diag_source_select_one = diag_config[alu_diag_pkg::sel_one_lsb +: 4];
    assign diag_source_select_two = diag_config[alu_diag_pkg::sel_two_lsb +: 4];

    mux_route u_route (
        .enable      (diag_config[alu_diag_pkg::mux_en_bit]),
        .pairing     (diag_config[alu_diag_pkg::pairing_bit]),
        .bus_sel     (diag_config[alu_diag_pkg::bus_sel_bit]),
        .even_out_on (mux_even_out_on),
        .odd_out_on  (mux_odd_out_on),
        .dual_source (mux_dual_source)
    );

    property p_arg_first;
        @(posedge clk) disable iff (!rst_b)
        (ce && alu_selftest_select == 2'h1 && oversampling && sample_even && !conv_second)
            |=> (alu_input == ADC_W'($past(alu_arg_even_first)) && alu_injecting);
    endproperty
    a_arg_first: assert property (p_arg_first) else $error("first argument not injected");

    property p_arg_second;
        @(posedge clk) disable iff (!rst_b)
        (ce && alu_selftest_select == 2'h1 && oversampling && sample_even && conv_second)
            |=> (alu_input == ADC_W'($past(alu_arg_even_second)));
    endproperty
    a_arg_second: assert property (p_arg_second) else $error("second argument not injected");

    property p_no_select;
        @(posedge clk) disable iff (!rst_b)
        (ce && alu_selftest_select != 2'h1) |=> !alu_injecting;
    endproperty
    a_no_select: assert property (p_no_select) else $error("injection without select");

    property p_arg_width;
        @(posedge clk) disable iff (!rst_b)
        (wb_ack_o && !wb_we_i && wb_dat_o[31:12] != 20'h0)
            |-> $past(idx) == alu_diag_pkg::idx_diag_config;
    endproperty
    a_arg_width: assert property (p_arg_width) else $error("upper bits read nonzero");

    property p_cfg_write;
        @(posedge clk) disable iff (!rst_b)
        (ce && wr && idx == alu_diag_pkg::idx_diag_config && wb_sel_i == 4'hf)
            |=> diag_config == $past(wb_dat_i[15:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_level;
        @(posedge clk) disable iff (!rst_b)
        test_current_steps == 5'(diag_config[15:12]) + 5'h01;
    endproperty
    a_level: assert property (p_level) else $error("level steps wrong");

    property p_polarity;
        @(posedge clk) disable iff (!rst_b)
        aux_test_source == diag_config[11];
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    property p_pairing;
        @(posedge clk) disable iff (!rst_b)
        (diag_config[8] && diag_config[9]) |-> (mux_even_out_on != mux_odd_out_on)
            && (mux_odd_out_on == diag_config[10]);
    endproperty
    a_pairing: assert property (p_pairing) else $error("paired routing wrong");

    property p_mux_off;
        @(posedge clk) disable iff (!rst_b)
        !diag_config[8] |-> !(mux_even_out_on || mux_odd_out_on || mux_dual_source);
    endproperty
    a_mux_off: assert property (p_mux_off) else $error("mux source on while disabled");

    property p_pass;
        @(posedge clk) disable iff (!rst_b)
        (ce && !(alu_selftest_select == 2'h1 && oversampling && sample_even))
            |=> alu_input == $past(adc_result);
    endproperty
    a_pass: assert property (p_pass) else $error("real result altered");

    // request taken, then one-cycle ack
    sequence s_taken;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack;
        @(posedge clk) disable iff (!rst_b)
        (s_taken ##1 ce) |-> s_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
endmodule
`default_nettype wire

// ===== inc/alu_diag_pkg.sv
package alu_diag_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  idx_even_first  = 8'h69;
    localparam logic [7:0]  idx_even_second = 8'h6a;
    localparam logic [7:0]  idx_diag_config = 8'h6b;
    localparam logic [7:0]  idx_selftest    = 8'h6c;
    localparam int          arg_w           = 12;
    localparam logic [11:0] arg_reset       = 12'h000;
    localparam logic [15:0] diag_reset      = 16'h0000;
    localparam logic [1:0]  selftest_reset  = 2'h0;
    localparam logic [1:0]  selftest_alu    = 2'h1;
    localparam int          level_lsb       = 12;
    localparam int          polarity_bit    = 11;
    localparam int          bus_sel_bit     = 10;
    localparam int          pairing_bit     = 9;
    localparam int          mux_en_bit      = 8;
    localparam int          sel_two_lsb     = 4;
    localparam int          sel_one_lsb     = 0;
endpackage

// ===== rtl/mux_route.sv
`timescale 1ns/100ps
`default_nettype none
// multiplexer test-source routing onto the two outputs
module mux_route (
    // configuration
    input  wire logic       enable,
    input  wire logic       pairing,
    input  wire logic       bus_sel,
    // source connections
    output logic            even_out_on,
    output logic            odd_out_on,
    output logic            dual_source
);
    always_comb begin
        even_out_on = enable & (~pairing | ~bus_sel);
        odd_out_on  = enable & (~pairing | bus_sel);
        dual_source = enable & ~pairing;
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack;
    logic        ov = 1'b0;
    logic        ev = 1'b0;
    logic        cs = 1'b0;
    logic [11:0] adc = 12'h000;
    logic [11:0] alu_in;
    logic        inj;
    logic [4:0]  steps;
    logic        aux, m_even, m_odd, m_dual;
    logic [3:0]  s_one, s_two;
    logic [31:0] exp_q[$];
    logic [11:0] a1, a2;
    logic [15:0] d;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;
    alu_diag_regs u_alu_diag_regs (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .oversampling(ov), .sample_even(ev),
        .conv_second(cs), .adc_result(adc), .alu_input(alu_in), .alu_injecting(inj),
        .test_current_steps(steps), .aux_test_source(aux), .mux_even_out_on(m_even),
        .mux_odd_out_on(m_odd), .mux_dual_source(m_dual),
        .diag_source_select_one(s_one), .diag_source_select_two(s_two));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat <= v;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(1'b0, idx, 32'h0);
    endtask
    // read data checked as each read ack appears
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 6000) begin
            err_total++;
            wrap_up();
        end
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) chk(32'hdead, 32'h0);
            else chk(dat_o, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h56631f39));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 8'h69; i <= 8'h6c; i++) rd(i[7:0], 32'h0);
        chk(steps, 5'h01);
        wb(1'b1, 8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
        $display("reset and unmapped test done");
        for (int i = 0; i < 4; i++) begin
            a1 = 12'($urandom);
            a2 = 12'($urandom);
            wb(1'b1, alu_diag_pkg::idx_even_first, {20'hfffff, a1});
            wb(1'b1, alu_diag_pkg::idx_even_second, {20'habcde, a2});
            rd(alu_diag_pkg::idx_even_first, {20'h0, a1});
            rd(alu_diag_pkg::idx_even_second, {20'h0, a2});
        end
        $display("argument test done");
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            d[10:8] = i[2:0];
            wb(1'b1, alu_diag_pkg::idx_diag_config, {16'($urandom), d});
            rd(alu_diag_pkg::idx_diag_config, {16'h0, d});
            chk(steps, {1'b0, d[15:12]} + 5'h01);
            chk(aux, d[11]);
            chk(m_dual, d[8] & ~d[9]);
            chk(m_even, d[8] & (~d[9] | ~d[10]));
            chk(m_odd, d[8] & (~d[9] | d[10]));
            chk({s_two, s_one}, d[7:0]);
        end
        $display("configuration test done");
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, alu_diag_pkg::idx_selftest, s);
            rd(alu_diag_pkg::idx_selftest, s);
            for (int k = 0; k < 8; k++) begin
                @(posedge clk);
                {ov, ev, cs} <= k[2:0];
                adc <= 12'($urandom);
                @(posedge clk);
                @(negedge clk);
                if (s == 1 && k[2] && k[1]) begin
                    chk(alu_in, k[0] ? a2 : a1);
                    chk(inj, 1'b1);
                end else begin
                    chk(alu_in, adc);
                    chk(inj, 1'b0);
                end
            end
        end
        $display("injection test done");
        a1 = alu_in;
        @(posedge clk);
        ce <= 1'b0;
        {ov, ev, cs} <= 3'b000;
        adc <= a1 ^ 12'hfff;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(alu_in, a1);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(alu_in, a1 ^ 12'hfff);
        $display("clock enable test done");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(alu_in, 12'h000);
        chk(inj, 1'b0);
        chk(steps, 5'h01);
        for (int i = 8'h69; i <= 8'h6c; i++) rd(i[7:0], 32'h0);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
